// >>> rtl/csdr_card_specific_data.sv
// Card specific data record: fixed, model and programmable fields with read port
//
// Summary of operation
// [RQ1] Top bits hold layout version 2, next four bits protocol revision 3, read-only.
// [RQ2] Async access time code at 119:112; clocked access time, 100-cycle units, 111:104.
// [RQ3] Erase unit multiplier at 41:37 is read-only, all ones.
// [RQ4] Protect unit size 3 at 36:32; protect unit enable at 31 reads 1.
// [RQ5] Write block size exponent at 25:22 reads 9, meaning 512-byte blocks.
// [RQ6] Partial write allowed bit 21 reads 0; bits 20:16 read zero.
// [RQ7] Capacity count 73:62 and multiplier 49:47 are per model, read-only.
// [RQ8] Host supplies checksum 7:1; bit 0 always reads 1.
// [RQ9] Layout version stays permanently binary 10.
// [RQ10] Writes change only programmable fields; read-only fields ignore writes.
`include "csdr_regs.svh"

module csdr_card_specific_data #(
    parameter logic [11:0] CAPACITY_COUNT   = 12'h7A7,
    parameter logic [2:0]  CAPACITY_MULT    = 3'h3,
    parameter logic [4:0]  ERASE_UNIT_SIZE  = 5'h00,
    parameter logic [11:0] SUPPLY_CURRENTS  = 12'h000
) (
    // Clock and reset
    input  wire logic                  CLK,
    input  wire logic                  RST_N,
    // Record write from the command layer
    input  wire logic                  WR_STB,
    input  wire csdr_pkg::csdr_record_t WR_DATA,
    // Record read to the command layer
    input  wire logic                  RD_STB,
    output csdr_pkg::csdr_record_t     RD_DATA,
    output logic                       RD_VALID
);
    // ************************************************************
    // Parameter checks
    // ************************************************************
    if (CAPACITY_COUNT == 12'h000)
        $error("capacity count of zero is not a usable card size");

    // ************************************************************
    // Programmable fields
    // ************************************************************
    wire csdr_pkg::csdr_flags_t    flags;
    wire csdr_pkg::csdr_checksum_t checksum;

    // Only bits 15:1 ever reach storage; the rest of a write is dropped
    csdr_prog_field #(
        .WIDTH (8),
        .RESET (`CSDR_FLAGS_RESET)
    ) u_flags (
        .clk        (CLK),
        .rst_n      (RST_N),
        .load       (WR_STB),
        .load_value (WR_DATA[`CSDR_FLAGS_LSB +: 8]),
        .value      (flags)
    ); // RQ10

    csdr_prog_field #(
        .WIDTH (7),
        .RESET (`CSDR_CHECKSUM_RESET)
    ) u_checksum (
        .clk        (CLK),
        .rst_n      (RST_N),
        .load       (WR_STB),
        .load_value (WR_DATA[`CSDR_CHECKSUM_LSB +: 7]),
        .value      (checksum)
    ); // RQ8

    // ************************************************************
    // Record assembly
    // ************************************************************
    wire csdr_pkg::csdr_record_t record_now;

    assign record_now = {
        `CSDR_LAYOUT_VERSION,    // RQ1 RQ9
        `CSDR_PROTOCOL_REV,      // RQ1
        2'h0,
        `CSDR_ASYNC_ACCESS,      // RQ2
        `CSDR_CLOCKED_ACCESS,    // RQ2
        `CSDR_TRANSFER_RATE,
        `CSDR_CMD_CLASSES,
        `CSDR_READ_BLOCK_EXP,
        4'h0,
        2'h0,
        CAPACITY_COUNT,          // RQ7
        SUPPLY_CURRENTS,
        CAPACITY_MULT,           // RQ7
        ERASE_UNIT_SIZE,
        `CSDR_ERASE_UNIT_MULT,   // RQ3
        `CSDR_PROTECT_UNIT_SIZE, // RQ4
        `CSDR_PROTECT_UNIT_EN,   // RQ4
        `CSDR_DEFAULT_ECC,
        `CSDR_WRITE_FACTOR,
        `CSDR_WRITE_BLOCK_EXP,   // RQ5
        `CSDR_WRITE_PARTIAL,     // RQ6
        5'h00,                   // RQ6
        flags,
        checksum,                // RQ8
        `CSDR_ALWAYS_ONE         // RQ8
    };

    // ************************************************************
    // Read port
    // ************************************************************
    // Snapshot taken on the strobe so a shift-out sees a stable record
    wire csdr_pkg::csdr_record_t next_rd_data;

    assign next_rd_data = RD_STB ? record_now : RD_DATA;

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            RD_DATA  <= '0;
            RD_VALID <= 1'h0;
        end
        else
        begin
            RD_DATA  <= next_rd_data;
            RD_VALID <= RD_STB;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_header;
        @(posedge CLK) disable iff (!RST_N)
        RD_STB |=> RD_VALID && RD_DATA[127:126] == 2'h2 && RD_DATA[125:122] == 4'h3;
    endproperty
    a_header: assert property (p_header) else $error("header fields wrong"); // RQ1

    property p_access;
        @(posedge CLK) disable iff (!RST_N)
        RD_VALID |-> RD_DATA[119:112] == 8'h26 && RD_DATA[111:104] == 8'h01;
    endproperty
    a_access: assert property (p_access) else $error("access time fields wrong"); // RQ2

    property p_erase;
        @(posedge CLK) disable iff (!RST_N)
        RD_VALID |-> RD_DATA[41:37] == 5'h1F;
    endproperty
    a_erase: assert property (p_erase) else $error("erase multiplier wrong"); // RQ3

    property p_protect;
        @(posedge CLK) disable iff (!RST_N)
        RD_VALID |-> RD_DATA[36:32] == 5'h03 && RD_DATA[31];
    endproperty
    a_protect: assert property (p_protect) else $error("protect unit fields wrong"); // RQ4

    property p_wblock;
        @(posedge CLK) disable iff (!RST_N)
        RD_VALID |-> RD_DATA[25:22] == 4'h9;
    endproperty
    a_wblock: assert property (p_wblock) else $error("write block exponent wrong"); // RQ5

    property p_partial;
        @(posedge CLK) disable iff (!RST_N)
        RD_VALID |-> RD_DATA[21:16] == 6'h00;
    endproperty
    a_partial: assert property (p_partial) else $error("partial bit or reserved set"); // RQ6

    property p_capacity;
        @(posedge CLK) disable iff (!RST_N)
        RD_VALID |-> RD_DATA[73:62] == CAPACITY_COUNT && RD_DATA[49:47] == CAPACITY_MULT;
    endproperty
    a_capacity: assert property (p_capacity) else $error("capacity fields wrong"); // RQ7

    property p_checksum;
        @(posedge CLK) disable iff (!RST_N)
        WR_STB ##1 RD_STB |=> RD_DATA[7:1] == $past(WR_DATA[7:1], 2) && RD_DATA[0];
    endproperty
    a_checksum: assert property (p_checksum) else $error("checksum not as written"); // RQ8

    property p_version_kept;
        @(posedge CLK) disable iff (!RST_N)
        RD_VALID ##1 (!RD_STB)[*2] |-> RD_DATA[127:126] == 2'h2 && $stable(RD_DATA);
    endproperty
    a_version_kept: assert property (p_version_kept) else $error("layout version moved"); // RQ9

    property p_ro_kept;
        @(posedge CLK) disable iff (!RST_N)
        RD_VALID ##1 (RD_STB && WR_STB) |=> RD_DATA[127:16] == $past(RD_DATA[127:16], 1);
    endproperty
    a_ro_kept: assert property (p_ro_kept) else $error("read-only field changed"); // RQ10

    property p_bit_zero;
        @(posedge CLK) disable iff (!RST_N)
        RD_VALID |-> RD_DATA[0];
    endproperty
    a_bit_zero: assert property (p_bit_zero) else $error("bit zero not one"); // RQ8

    // ************************************************************
    // Assertions on reads that follow a write
    // ************************************************************
    // Any write must leave the version, capacity and bit 41:16 fixed fields where they were
    property p_vers_wr;
        @(posedge CLK) disable iff (!RST_N)
        WR_STB ##1 RD_STB |=> RD_DATA[127:126] == 2'h2 && RD_DATA[125:122] == 4'h3;
    endproperty
    a_vers_wr: assert property (p_vers_wr) else $error("version moved by write"); // RQ9

    property p_fixed_wr;
        @(posedge CLK) disable iff (!RST_N)
        WR_STB ##1 RD_STB |=> RD_DATA[41:31] == {5'h1F, 5'h03, 1'h1} &&
            RD_DATA[30:16] == {2'h0, 3'h4, 4'h9, 1'h0, 5'h00};
    endproperty
    a_fixed_wr: assert property (p_fixed_wr) else $error("fixed field written"); // RQ10

    property p_model_wr;
        @(posedge CLK) disable iff (!RST_N)
        WR_STB ##1 RD_STB |=> RD_DATA[73:62] == CAPACITY_COUNT && RD_DATA[49:47] == CAPACITY_MULT;
    endproperty
    a_model_wr: assert property (p_model_wr) else $error("model field written"); // RQ7

    // ************************************************************
    // Read port timing
    // ************************************************************
    property p_valid_one;
        @(posedge CLK) disable iff (!RST_N)
        !RD_STB |=> !RD_VALID;
    endproperty
    a_valid_one: assert property (p_valid_one) else $error("valid without a read");

    // Shift-out relies on the snapshot standing between reads
    property p_rd_hold;
        @(posedge CLK) disable iff (!RST_N)
        !RD_STB |=> $stable(RD_DATA);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
endmodule

// >>> rtl/csdr_pkg.sv
// Types shared by the card specific data record block
package csdr_pkg;
    typedef logic [127:0] csdr_record_t;
    typedef logic [7:0]   csdr_flags_t;
    typedef logic [6:0]   csdr_checksum_t;
endpackage

// >>> rtl/csdr_prog_field.sv
// Programmable record field held in flip-flops, loaded on a write strobe
module csdr_prog_field #(
    parameter int                WIDTH = 8,
    parameter logic [WIDTH-1:0]  RESET = '0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Load
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    // Held value
    output logic      [WIDTH-1:0] value
);
    // A zero-width field has nothing to hold
    if (WIDTH < 1)
        $error("field width must be at least one");

    wire logic [WIDTH-1:0] next_value;

    assign next_value = load ? load_value : value;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            value <= RESET;
        else
            value <= next_value;
    end
endmodule

// >>> rtl/csdr_regs.svh
// Field positions, fixed values and reset values of the card specific data record
`ifndef CSDR_REGS_SVH
`define CSDR_REGS_SVH

`define CSDR_WIDTH             128

// Fixed field values
`define CSDR_LAYOUT_VERSION    2'h2
`define CSDR_PROTOCOL_REV      4'h3
`define CSDR_ASYNC_ACCESS      8'h26
`define CSDR_CLOCKED_ACCESS    8'h01
`define CSDR_TRANSFER_RATE     8'h2A
`define CSDR_CMD_CLASSES       12'h0F5
`define CSDR_READ_BLOCK_EXP    4'h9
`define CSDR_ERASE_UNIT_MULT   5'h1F
`define CSDR_PROTECT_UNIT_SIZE 5'h03
`define CSDR_PROTECT_UNIT_EN   1'h1
`define CSDR_DEFAULT_ECC       2'h0
`define CSDR_WRITE_FACTOR      3'h4
`define CSDR_WRITE_BLOCK_EXP   4'h9
`define CSDR_WRITE_PARTIAL     1'h0
`define CSDR_ALWAYS_ONE        1'h1

// Field positions (low bit of each field)
`define CSDR_FLAGS_LSB         8
`define CSDR_CHECKSUM_LSB      1

// Reset values of the programmable fields
`define CSDR_FLAGS_RESET       8'h40
`define CSDR_CHECKSUM_RESET    7'h00

`endif

// >>> test/csdr_host_model.sv
// Host model that writes and reads the card specific data record
module csdr_host_model (
    // Clock
    input  wire logic                   clk,
    // Record write
    output logic                        wr_stb,
    output csdr_pkg::csdr_record_t      wr_data,
    // Record read
    output logic                        rd_stb,
    input  wire csdr_pkg::csdr_record_t rd_data,
    input  wire logic                   rd_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        wr_stb  = 1'h0;
        wr_data = '0;
        rd_stb  = 1'h0;
    end
    // Host supplies the whole image, checksum included
    task automatic write_rec(input csdr_pkg::csdr_record_t d);
        @(negedge clk);
        wr_stb  = 1'h1;
        wr_data = d;
        @(negedge clk);
        wr_stb  = 1'h0;
        wr_data = ~d;
    endtask
    // Gives up after four cycles so a dead port cannot hang the run
    task automatic read_rec(output csdr_pkg::csdr_record_t q, output logic ok);
        @(negedge clk);
        rd_stb = 1'h1;
        @(negedge clk);
        rd_stb = 1'h0;
        ok     = 1'h0;
        q      = 'x;
        for (int n = 0; n < 4 && !ok; n++)
        begin
            if (rd_valid === 1'h1)
            begin
                q  = rd_data;
                ok = 1'h1;
            end
            else
                @(negedge clk);
        end
    endtask
    // Read, write d0, read with write d1 in one cycle, read again; fixed cycle count
    task automatic rw_rec(input  csdr_pkg::csdr_record_t d0,
                          input  csdr_pkg::csdr_record_t d1,
                          output csdr_pkg::csdr_record_t q_old,
                          output csdr_pkg::csdr_record_t q_new,
                          output logic                   ok);
        @(negedge clk);
        rd_stb  = 1'h1;
        @(negedge clk);
        rd_stb  = 1'h0;
        wr_stb  = 1'h1;
        wr_data = d0;
        @(negedge clk);
        rd_stb  = 1'h1;
        wr_data = d1;
        @(negedge clk);
        wr_stb  = 1'h0;
        wr_data = ~d1;
        ok      = (rd_valid === 1'h1);
        q_old   = rd_data;
        @(negedge clk);
        rd_stb  = 1'h0;
        ok      = ok && (rd_valid === 1'h1);
        q_new   = rd_data;
    endtask
endmodule

// >>> test/test_card_specific_data_register.sv
// Self-checking bench for the card specific data record
module test_card_specific_data_register;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // Bench signals and checks
    // ************************************************************
    localparam logic [11:0] CAP = 12'hF4F;
    int                     n_errors = 0;
    int                     num_checks = 0;
    logic                   clk;
    logic                   rst_n;
    logic                   wr_stb;
    logic                   rd_stb;
    logic                   rd_valid;
    logic                   ok;
    csdr_pkg::csdr_record_t wr_data;
    csdr_pkg::csdr_record_t rd_data;
    csdr_pkg::csdr_record_t q;
    csdr_pkg::csdr_record_t q_new;
    always #25 clk = ~clk;
    csdr_card_specific_data #(.CAPACITY_COUNT(CAP)) dut (.CLK(clk), .RST_N(rst_n),
        .WR_STB(wr_stb), .WR_DATA(wr_data), .RD_STB(rd_stb), .RD_DATA(rd_data),
        .RD_VALID(rd_valid));
    csdr_host_model host (.clk(clk), .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb),
        .rd_data(rd_data), .rd_valid(rd_valid));
    task automatic check(string name, csdr_pkg::csdr_record_t seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Expected record for the given programmable fields
    function automatic csdr_pkg::csdr_record_t exp_rec(logic [7:0] fl, logic [6:0] ck);
        return {2'h2, 4'h3, 2'h0, 8'h26, 8'h01, 8'h2A, 12'h0F5, 4'h9, 4'h0, 2'h0, CAP,
                12'h000, 3'h3, 5'h00, 5'h1F, 5'h03, 1'h1, 2'h0, 3'h4, 4'h9, 1'h0, 5'h00,
                fl, ck, 1'h1};
    endfunction
    // Reads the record and compares every field against the fixed layout
    task automatic check_rec(logic [7:0] fl, logic [6:0] ck);
        csdr_pkg::csdr_record_t e;
        e = exp_rec(fl, ck);
        host.read_rec(q, ok);
        check("read_valid", ok, 1'h1);
        if (ok !== 1'h1)
            results();
        check("version", q[127:122], e[127:122]);
        check("access", q[119:104], e[119:104]);
        check("erase_mult", q[41:37], e[41:37]);
        check("protect", q[36:31], e[36:31]);
        check("wr_block", q[25:22], e[25:22]);
        check("partial", q[21:16], e[21:16]);
        check("capacity", {q[73:62], q[49:47]}, {e[73:62], e[49:47]});
        check("checksum", q[7:0], e[7:0]);
        check("record", q, e);
        @(negedge clk);
        check("valid_pulse", rd_valid, 1'h0);
        check("read_hold", rd_data, q);
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        clk   = 1'h0;
        rst_n = 1'h0;
        repeat (3) @(negedge clk);
        check("reset_data", rd_data, '0);
        rst_n = 1'h1;
        check_rec(8'h40, 7'h00);
        host.write_rec('1);
        check_rec(8'hFF, 7'h7F);
        host.write_rec({112'h0, 16'hA5A4});
        host.write_rec({112'h0, 16'h5A5B});
        check_rec(8'h5A, 7'h2D);
        host.write_rec('0);
        check_rec(8'h00, 7'h00);
        // A read taken with a write returns the image from before that write
        host.rw_rec({112'h0, 16'h1233}, {{112{1'h1}}, 16'hC3FE}, q, q_new, ok);
        check("rw_valid", ok, 1'h1);
        check("rw_old", q, exp_rec(8'h12, 7'h19));
        check("rw_new", q_new, exp_rec(8'hC3, 7'h7F));
        rst_n = 1'h0;
        @(negedge clk);
        check("reset_valid", rd_valid, 1'h0);
        check("reset_clear", rd_data, '0);
        rst_n = 1'h1;
        check_rec(8'h40, 7'h00);
        results();
    end
endmodule
